// File: src/rst_pkg.sv
// Constants for the system and test-port reset logic.
// Assumes one 40 MHz clock and asynchronous active-low reset pins.
package rst_pkg;
  localparam int SYNC_STAGES = 2;
  localparam int BOOT_SAMPLES = 2;
  localparam logic [31:0] RESET_FETCH_ADDR = 32'h0000_0000;
  localparam logic [31:0] RESET_PSR = 32'h0000_00d3;
  localparam logic [1:0] BOOT_SAMPLE_INIT = 2'h0;
  localparam logic STRAP_INIT = 1'h0;
  localparam int CLK_PERIOD_NS = 25;
  localparam int MIN_PULSE_US = 92;
  localparam int MIN_PULSE_CYCLES = (MIN_PULSE_US * 1000) / CLK_PERIOD_NS;
endpackage

// File: src/system_and_tap_reset_logic.sv
// Reset sequencing for the core, peripherals and test-port controllers.
// Assumes the pins come from a supervisor and a probe, unsynchronised.
`timescale 1ns/1ps
module system_and_tap_reset_logic #(
  parameter int SYNC_STAGES = rst_pkg::SYNC_STAGES, // Release chain depth.
  parameter int BOOT_SAMPLES = rst_pkg::BOOT_SAMPLES // Strap window depth.
) (
  input wire logic clk_in, // Default active clock.
  input wire logic arst_n_in, // Power-on reset, active low.
  input wire logic system_reset_in_n, // System reset pin.
  input wire logic test_port_reset_in_n, // Test-port reset pin.
  input wire logic boot_select_pin, // Boot memory select pin.
  input wire logic test_port_select_pin, // Scan or emulator select.
  output logic sys_rst_n_out, // Synchronised internal reset.
  output logic periph_rst_n_out, // Peripheral register reset.
  output logic core_halt_out, // Core stopped.
  output logic [31:0] fetch_addr_out, // First fetch address.
  output logic [31:0] psr_reset_out, // Status register default.
  output logic boot_internal_out, // High boots internal ROM.
  output logic scan_mode_out, // Latched test-port select.
  output logic scan_tap_rst_n_out, // Scan TAP reset.
  output logic emu_tap_rst_n_out, // Emulator TAP reset.
  output logic debug_exit_out, // Core leaves debug state.
  output logic idcode_sel_out // Identity instruction selected.
);
  // Elaboration guards: the shift expressions slice [N-2:0], so both
  // chains need at least two stages or they cannot be built.
  if (SYNC_STAGES < 2) begin : g_sync_depth_bad
    $error("release chain needs at least two stages");
  end
  if (BOOT_SAMPLES < 2) begin : g_boot_depth_bad
    $error("strap window needs at least two samples");
  end

  // Everything the block remembers about a system reset lives here.
  typedef struct packed {
    logic [SYNC_STAGES-1:0] sync; // Release chain, bit 0 first.
    logic [BOOT_SAMPLES-1:0] boot_smp; // Last boot-select samples.
    logic boot; // Frozen boot memory choice.
    logic sel; // Frozen test-port choice.
  } state_s;

  // Value the whole state takes while a system reset holds. Only
  // constants appear here, so every bit maps onto a plain async-clear
  // flop with no feedback through the reset path.
  localparam state_s RESET_ST = '{
    sync: '0,
    boot_smp: BOOT_SAMPLES'(rst_pkg::BOOT_SAMPLE_INIT),
    boot: rst_pkg::STRAP_INIT,
    sel: rst_pkg::STRAP_INIT
  };

  state_s st_ff;
  state_s nxt_st;
  logic sys_n;
  logic running;
  logic pin_sel_m_ff;
  logic pin_sel_ff;
  logic pin_boot_m_ff;
  logic pin_boot_ff;

  // One decode serves the scan, emulator and debug outputs: is the controller named
  // by want_scan being reset right now? It reads only the pin and the
  // frozen choice, never a clock, so a probe can reset a stopped part.
  function automatic logic tap_hit(input logic pin_n,
                                   input logic scan_sel,
                                   input logic want_scan);
    tap_hit = !pin_n && (scan_sel == want_scan);
  endfunction

  // Combined reset: either source clears the state register immediately, with no
  // clock edge needed, so the core halts mid-instruction.
  assign sys_n = arst_n_in & system_reset_in_n;

  // The last stage of the release chain is the internal reset itself.
  assign running = st_ff.sync[SYNC_STAGES-1];

  // Pin synchronisers for the straps. They clear only on power-on reset
  // and keep sampling through a system reset, so the cycles just before
  // release already carry a clean, settled level.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pin_boot_m_ff <= rst_pkg::STRAP_INIT;
      pin_boot_ff <= rst_pkg::STRAP_INIT;
      pin_sel_m_ff <= rst_pkg::STRAP_INIT;
      pin_sel_ff <= rst_pkg::STRAP_INIT;
    end else begin
      pin_boot_m_ff <= boot_select_pin;
      pin_boot_ff <= pin_boot_m_ff;
      pin_sel_m_ff <= test_port_select_pin;
      pin_sel_ff <= pin_sel_m_ff;
    end
  end

  // Next state. The chain fills with ones from bit 0. While the last
  // stage is still low the straps follow the synchronised pins, and the
  // edge that raises it is the last one to sample them, so the choice
  // is the pin level of the final cycles before release and then holds.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.sync = {st_ff.sync[SYNC_STAGES-2:0], 1'b1};
    if (!running) begin
      nxt_st.boot_smp = {st_ff.boot_smp[BOOT_SAMPLES-2:0],
                         pin_boot_ff};
      nxt_st.boot = pin_boot_ff;
      nxt_st.sel = pin_sel_ff;
    end
  end

  // State register. Assertion clears it at once; release waits for the
  // chain. Trade-off: the straps read their init value while a reset
  // holds and are recaptured in the two edges after release, which keeps
  // the reset branch constant-only at the cost of a short blind window.
  always_ff @(posedge clk_in or negedge sys_n) begin
    if (!sys_n) begin
      st_ff <= RESET_ST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Core and peripheral resets come straight from the chain output, so
  // both leave reset on the same clock edge.
  assign sys_rst_n_out = running;
  assign periph_rst_n_out = running;
  assign core_halt_out = ~running;

  // Reset-time constants for the core; only these two registers get
  // defined values, the rest of the core is left as it powers up.
  assign fetch_addr_out = rst_pkg::RESET_FETCH_ADDR;
  assign psr_reset_out = rst_pkg::RESET_PSR;

  // Frozen strap choices, read by the memory map and the test port.
  assign boot_internal_out = st_ff.boot;
  assign scan_mode_out = st_ff.sel;

  // Test-port resets are pure logic from the pin, so they need no test
  // clock and never touch the system reset chain. A limitation: while a
  // system reset holds, the choice reads its init value and a probe
  // reset goes to the emulator controller.
  assign scan_tap_rst_n_out = ~tap_hit(test_port_reset_in_n, st_ff.sel,
                                       1'b1);
  assign emu_tap_rst_n_out = ~tap_hit(test_port_reset_in_n, st_ff.sel,
                                      1'b0);
  assign debug_exit_out = tap_hit(test_port_reset_in_n, st_ff.sel,
                                  1'b0);
  assign idcode_sel_out = ~test_port_reset_in_n;

  // Internal reset only rises after SYNC_STAGES clock edges.
  chk_release_delay: assert property (
    @(posedge clk_in) disable iff (!sys_n)
    $rose(st_ff.sync[0]) |-> !sys_rst_n_out ##1 sys_rst_n_out)
    else $error("internal reset released too early");
  // Boot strap stays frozen while running.
  chk_boot_frozen: assert property (
    @(posedge clk_in) disable iff (!sys_n)
    sys_rst_n_out && $past(sys_rst_n_out) |-> $stable(boot_internal_out))
    else $error("boot select changed while running");
  chk_sel_frozen: assert property (
    @(posedge clk_in) disable iff (!sys_n)
    sys_rst_n_out && $past(sys_rst_n_out) |-> $stable(scan_mode_out))
    else $error("test select changed while running");
  chk_halt_match: assert property (
    @(posedge clk_in) core_halt_out == !sys_rst_n_out)
    else $error("halt and reset disagree");
  chk_periph_rst: assert property (
    @(posedge clk_in) !sys_n |-> !periph_rst_n_out)
    else $error("peripherals not reset");
  chk_tap_one: assert property (
    @(posedge clk_in) scan_tap_rst_n_out || emu_tap_rst_n_out)
    else $error("both test controllers reset");
  chk_idcode_select: assert property (
    @(posedge clk_in) !test_port_reset_in_n |-> idcode_sel_out)
    else $error("identity instruction not selected");
  chk_fetch_zero: assert property (
    @(posedge clk_in) $rose(sys_rst_n_out) |->
    fetch_addr_out == rst_pkg::RESET_FETCH_ADDR)
    else $error("first fetch not at zero");

  // The checks below watch the chain, the strap capture and the test
  // port routing edge by edge; ten of the 21 are disabled while a system reset
  // holds, since the state is then forced and says nothing.

  // The core is halted whenever either reset source is low.
  chk_halt_async: assert property (
    @(posedge clk_in) !sys_n |-> core_halt_out)
    else $error("core running during reset");

  // The chain is empty while a reset holds.
  chk_chain_clear: assert property (
    @(posedge clk_in) !sys_n |-> st_ff.sync == '0)
    else $error("release chain not cleared");

  // Internal reset rises only after the stage before it was high.
  chk_release_edge: assert property (
    @(posedge clk_in) disable iff (!sys_n)
    $rose(sys_rst_n_out) |-> $past(st_ff.sync[SYNC_STAGES-2]))
    else $error("internal reset skipped a stage");

  // Bit 0 of the chain fills one edge after the reset sources release.
  chk_chain_fill: assert property (
    @(posedge clk_in) disable iff (!sys_n)
    sys_n |=> st_ff.sync[0])
    else $error("release chain did not fill");

  // Internal reset stays low while the stage before it was low.
  chk_chain_hold: assert property (
    @(posedge clk_in) disable iff (!sys_n)
    !$past(st_ff.sync[SYNC_STAGES-2]) |-> !sys_rst_n_out)
    else $error("internal reset released early");

  // While held, the boot choice follows the synchronised pin.
  chk_boot_capture: assert property (
    @(posedge clk_in) disable iff (!sys_n)
    !sys_rst_n_out |=> boot_internal_out == $past(pin_boot_ff))
    else $error("boot select not captured");

  // While held, the test-port choice follows the synchronised pin.
  chk_sel_capture: assert property (
    @(posedge clk_in) disable iff (!sys_n)
    !sys_rst_n_out |=> scan_mode_out == $past(pin_sel_ff))
    else $error("test select not captured");

  // The boot choice is the newest sample of the window at release.
  chk_boot_sample: assert property (
    @(posedge clk_in) disable iff (!sys_n)
    $rose(sys_rst_n_out) |-> boot_internal_out == st_ff.boot_smp[0])
    else $error("boot choice not from sample window");

  // The sample window shifts in the pin while held.
  chk_boot_window: assert property (
    @(posedge clk_in) disable iff (!sys_n)
    !sys_rst_n_out |=> st_ff.boot_smp[0] == $past(pin_boot_ff))
    else $error("boot window not sampling");

  // The sample window stands still while running.
  chk_window_hold: assert property (
    @(posedge clk_in) disable iff (!sys_n)
    sys_rst_n_out |=> $stable(st_ff.boot_smp))
    else $error("boot window moved while running");

  // Scan mode: a probe reset reaches the scan controller.
  chk_scan_route: assert property (
    @(posedge clk_in) scan_mode_out && !test_port_reset_in_n |->
    !scan_tap_rst_n_out)
    else $error("scan controller not reset");

  // Scan mode: the emulator controller is never reset.
  chk_emu_spared: assert property (
    @(posedge clk_in) scan_mode_out |-> emu_tap_rst_n_out)
    else $error("emulator reset in scan mode");

  // Emulator mode: a probe reset reaches the emulator controller.
  chk_emu_route: assert property (
    @(posedge clk_in) !scan_mode_out && !test_port_reset_in_n |->
    !emu_tap_rst_n_out)
    else $error("emulator controller not reset");

  // Emulator mode: a probe reset takes the core out of debug.
  chk_debug_exit: assert property (
    @(posedge clk_in) !scan_mode_out && !test_port_reset_in_n |->
    debug_exit_out)
    else $error("core kept in debug state");

  // Scan mode never pulls the core out of debug.
  chk_debug_scan: assert property (
    @(posedge clk_in) scan_mode_out |-> !debug_exit_out)
    else $error("debug exit in scan mode");

  // With the probe pin high, no test controller is reset.
  chk_tap_idle: assert property (
    @(posedge clk_in) test_port_reset_in_n |->
    scan_tap_rst_n_out && emu_tap_rst_n_out)
    else $error("test controller reset while idle");

  // With the probe pin high, no identity or debug request stands.
  chk_idcode_idle: assert property (
    @(posedge clk_in) test_port_reset_in_n |->
    !idcode_sel_out && !debug_exit_out)
    else $error("test request while idle");

  // Once running, only a system reset stops the core.
  chk_run_kept: assert property (
    @(posedge clk_in) disable iff (!sys_n)
    sys_rst_n_out |=> sys_rst_n_out)
    else $error("core reset without system reset");

  // The status register default is the agreed constant.
  chk_psr_value: assert property (
    @(posedge clk_in) psr_reset_out == rst_pkg::RESET_PSR)
    else $error("status default wrong");

  // Peripheral and core resets leave together.
  chk_periph_follow: assert property (
    @(posedge clk_in) periph_rst_n_out == sys_rst_n_out)
    else $error("peripheral reset out of step");

  // The core resumes at the reset fetch address.
  chk_halt_release: assert property (
    @(posedge clk_in) disable iff (!sys_n)
    $fell(core_halt_out) |-> fetch_addr_out == rst_pkg::RESET_FETCH_ADDR)
    else $error("core resumed off the reset address");
endmodule

// File: test/reset_source.sv
// Model of the reset supervisor and debug probe beside the block.
// Assumes callers act just after a rising clock edge.
`timescale 1ns/1ps
module reset_source (
  input wire logic clk_in, // Default active clock.
  output logic sys_n_out, // System reset pin.
  output logic tap_n_out // Test-port reset pin.
);
  // Both pins start asserted, as a power-up supervisor would.
  initial begin
    sys_n_out = 1'b0;
    tap_n_out = 1'b0;
  end
  // A shorter hold would leave the core half reset.
  task automatic sys_pulse(input int cyc);
    sys_n_out = 1'b0;
    repeat (cyc) @(posedge clk_in);
    #2 sys_n_out = 1'b1;
  endtask
  // The probe drives its pin apart from the system one.
  task automatic tap_set(input logic lvl);
    tap_n_out = lvl;
  endtask
endmodule

// File: test/tb.sv
// Self-checking bench for the reset logic and its supervisor model.
// Assumes a 40 MHz clock; stimulus lands 2 ns after rising edges.
`timescale 1ns/1ps
module tb;
  logic clk_in = 1'b0, arst_n_in = 1'b0, b_pin = 1'b0, s_pin = 1'b0;
  logic sys_n, per_n, halt, boot_int, scan_m, sc_n, emu_n, dbg, id_sel;
  logic sys_pin_n, tap_pin_n;
  logic [31:0] fetch, psr;
  int mismatches = 0, n_tests = 0, cycles = 0;
  reset_source src (.clk_in(clk_in), .sys_n_out(sys_pin_n),
    .tap_n_out(tap_pin_n));
  system_and_tap_reset_logic dut (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .system_reset_in_n(sys_pin_n), .test_port_reset_in_n(tap_pin_n),
    .boot_select_pin(b_pin), .test_port_select_pin(s_pin),
    .sys_rst_n_out(sys_n), .periph_rst_n_out(per_n), .core_halt_out(halt),
    .fetch_addr_out(fetch), .psr_reset_out(psr),
    .boot_internal_out(boot_int), .scan_mode_out(scan_m),
    .scan_tap_rst_n_out(sc_n), .emu_tap_rst_n_out(emu_n),
    .debug_exit_out(dbg), .idcode_sel_out(id_sel));
  initial forever #12.5 clk_in = ~clk_in;
  // A hang ends the run with a counted mismatch.
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      final_report();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // Straps change after release to prove they stay frozen.
  task automatic sys_cycle(input logic b, input logic s);
    @(posedge clk_in) #2 b_pin = b;
    s_pin = s;
    fork
      src.sys_pulse(rst_pkg::MIN_PULSE_CYCLES);
      begin
        #3 chk("halt", halt, 1'b1);
        chk("periph", per_n, 1'b0);
      end
    join
    @(posedge clk_in) #1 chk("sync1", sys_n, 1'b0);
    @(posedge clk_in) #1 chk("sync2", sys_n, 1'b1);
    chk("halt_off", halt, 1'b0);
    chk("periph_off", per_n, 1'b1);
    #1 b_pin = !b;
    s_pin = !s;
    repeat (3) @(posedge clk_in);
    #1 chk("boot", boot_int, b);
    chk("scan", scan_m, s);
    chk("fetch", fetch, rst_pkg::RESET_FETCH_ADDR);
    chk("psr", psr, rst_pkg::RESET_PSR);
    $display("sys_cycle done");
  endtask
  // The probe pulse is timed off the system clock only; the test port
  // itself never sees a clock.
  task automatic tap_check(input logic s);
    @(posedge clk_in) #2 src.tap_set(1'b0);
    #1 chk("scan_tap", sc_n, !s);
    chk("emu_tap", emu_n, s);
    chk("dbg", dbg, !s);
    chk("id", id_sel, 1'b1);
    chk("sys_kept", sys_n, 1'b1);
    chk("halt_kept", halt, 1'b0);
    @(posedge clk_in) #2 src.tap_set(1'b1);
    #1 chk("id_off", id_sel, 1'b0);
    chk("dbg_off", dbg, 1'b0);
    chk("scan_off", sc_n, 1'b1);
    chk("emu_off", emu_n, 1'b1);
    $display("tap_check done");
  endtask
  task automatic final_report();
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_in);
    #2 arst_n_in = 1'b1;
    src.tap_set(1'b1);
    sys_cycle(1'b1, 1'b1);
    tap_check(1'b1);
    sys_cycle(1'b0, 1'b0);
    tap_check(1'b0);
    final_report();
  end
endmodule
